/* core/pgm_port.sv */
// Two 8-pin GPIO groups with interrupts, a group-one filter, pin mux and APB registers
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module pgm_port
  import pgm_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] grp1_pin_in,
  output logic [7:0] grp1_pin_out,
  output logic [7:0] grp1_pin_oe_n,
  output logic [7:0] grp1_pull_enable,
  output logic [7:0] grp1_pull_direction,
  output logic [7:0] grp1_pad_input_enable,
  output logic [7:0] grp1_periph_in,
  input wire logic [7:0] grp1_func0_out,
  input wire logic [7:0] grp1_func0_drive,
  input wire logic [7:0] grp1_mux_out,
  input wire logic [7:0] grp1_mux_drive,
  input wire logic [7:0] grp2_pin_in,
  output logic [7:0] grp2_pin_out,
  output logic [7:0] grp2_pin_oe_n,
  output logic [7:0] grp2_pull_enable,
  output logic [7:0] grp2_pull_direction,
  output logic [7:0] grp2_pad_input_enable,
  output logic [7:0] grp2_periph_in,
  input wire logic [7:0] grp2_func0_out,
  input wire logic [7:0] grp2_func0_drive,
  input wire logic [7:0] grp2_mux_out,
  input wire logic [7:0] grp2_mux_drive,
  input wire logic [7:0] grp2_lcd_seg_out,
  input wire logic [7:0] grp2_lcd_seg_drive,
  output logic irq
);

  typedef struct packed {
    logic [1:0][7:0] sync1;
    logic [1:0][7:0] sync2;
    logic [1:0][7:0] sync3;
    logic [1:0][7:0] filt;
    logic [1:0][7:0] in_value;
    logic [1:0][7:0] out_value;
    logic [1:0][7:0] input_enable;
    logic [1:0][7:0] output_enable;
    logic [1:0][7:0] pull_direction;
    logic [1:0][7:0] pull_enable;
    logic [1:0][7:0] irq_flag;
    logic [1:0][7:0] edge_select;
    logic [1:0][7:0] irq_enable;
    logic [7:0] filter_enable;
    logic [1:0][7:0] role_select;
    logic [1:0][15:0] func_field;
    logic [1:0][7:0] pin_out;
    logic [1:0][7:0] pin_oe_n;
    logic [1:0][7:0] periph_in;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } pgm_state_type;

  pgm_state_type r;
  pgm_state_type next_r;

  logic [1:0][7:0] pin_in_v;
  logic [1:0][7:0] f0_out;
  logic [1:0][7:0] f0_drv;
  logic [1:0][7:0] mx_out;
  logic [1:0][7:0] mx_drv;
  logic [1:0][7:0] f3_out;
  logic [1:0][7:0] f3_drv;

  assign pin_in_v = {grp2_pin_in, grp1_pin_in};
  assign f0_out = {grp2_func0_out, grp1_func0_out};
  assign f0_drv = {grp2_func0_drive, grp1_func0_drive};
  assign mx_out = {grp2_mux_out, grp1_mux_out};
  assign mx_drv = {grp2_mux_drive, grp1_mux_drive};
  // Group one has nothing on function 3
  assign f3_out = {grp2_lcd_seg_out, 8'h00}; // [R07] [R10]
  assign f3_drv = {grp2_lcd_seg_drive, 8'h00}; // [R07] [R10]

  // Register address decode
  logic [ADDR_W-1:0] local_ofs;
  logic addr_group;
  logic addr_ok;
  logic wr_now;
  logic [15:0] wdata16;
  logic [1:0][7:0] flag_clr;
  logic [1:0][7:0] edge_hit;

  assign addr_group = paddr >= ADDR_W'(PGM_GROUP_STRIDE);
  assign local_ofs = addr_group ? paddr - ADDR_W'(PGM_GROUP_STRIDE) : paddr;
  assign addr_ok = (paddr < ADDR_W'(2 * PGM_GROUP_STRIDE)) && (paddr[1:0] == 2'b00);
  // Writes take effect at the access edge, which is the one where pready is high
  assign wr_now = psel && penable && pwrite && r.pready && !r.pslverr;
  assign wdata16 = pwdata[15:0];

  function automatic logic [15:0] read_reg(input pgm_state_type s, input int g,
                                           input logic [ADDR_W-1:0] ofs);
    logic [15:0] v;
    v = PGM_RESET_HALF;
    case (ofs)
      ADDR_W'(PGM_OFS_DATA): v = {s.out_value[g], s.in_value[g]};
      ADDR_W'(PGM_OFS_IOEN): v = {s.input_enable[g], s.output_enable[g]};
      ADDR_W'(PGM_OFS_RCTL): v = {s.pull_direction[g], s.pull_enable[g]};
      ADDR_W'(PGM_OFS_INTF): v = {PGM_RESET_BYTE, s.irq_flag[g]}; // [R12]
      ADDR_W'(PGM_OFS_INTCTL): v = {s.edge_select[g], s.irq_enable[g]};
      ADDR_W'(PGM_OFS_FILTER): v = (g == 0) ? {PGM_RESET_BYTE, s.filter_enable}
                                           : PGM_FILTER_G2_VALUE; // [R11]
      ADDR_W'(PGM_OFS_MODE): v = {PGM_RESET_BYTE, s.role_select[g]};
      ADDR_W'(PGM_OFS_FUNC): v = s.func_field[g]; // [R05]
      default: v = PGM_RESET_HALF;
    endcase
    return v;
  endfunction

  always_comb begin
    next_r = r;
    flag_clr = '0;
    edge_hit = '0;
    // Pin synchronisers; the filter compares the second and third stages, the unfiltered path takes the second
    next_r.sync1 = pin_in_v;
    next_r.sync2 = r.sync1;
    next_r.sync3 = r.sync2;
    for (int g = 0; g < PGM_GROUPS; g++) begin
      for (int y = 0; y < PGM_PINS; y++) begin
        // Filter passes a level only after two equal samples; group two has none
        if (g == 0 && r.filter_enable[y]) begin
          if (r.sync2[g][y] == r.sync3[g][y]) begin
            next_r.filt[g][y] = r.sync2[g][y];
          end
        end else begin
          next_r.filt[g][y] = r.sync2[g][y]; // [R11]
        end
        next_r.in_value[g][y] = r.filt[g][y] & r.input_enable[g][y];
        // Edge select zero is rising, one is falling
        edge_hit[g][y] = r.edge_select[g][y] ? (r.in_value[g][y] & ~next_r.in_value[g][y])
                                             : (~r.in_value[g][y] & next_r.in_value[g][y]);
        // Pin drive: GPIO or the selected peripheral
        if (!r.role_select[g][y]) begin // [R04]
          next_r.pin_out[g][y] = r.out_value[g][y]; // [R01] [R02]
          next_r.pin_oe_n[g][y] = ~r.output_enable[g][y];
        end else begin
          case (pgm_func_type'(r.func_field[g][2*y +: PGM_FIELD_W])) // [R05]
            PGM_FUNC_0: begin
              next_r.pin_out[g][y] = f0_out[g][y]; // [R06] [R09]
              next_r.pin_oe_n[g][y] = ~f0_drv[g][y];
            end
            PGM_FUNC_MUX: begin
              next_r.pin_out[g][y] = mx_out[g][y]; // [R08]
              next_r.pin_oe_n[g][y] = ~mx_drv[g][y];
            end
            PGM_FUNC_3: begin
              next_r.pin_out[g][y] = f3_out[g][y]; // [R10]
              next_r.pin_oe_n[g][y] = ~f3_drv[g][y];
            end
            default: begin
              next_r.pin_out[g][y] = 1'b0; // [R07]
              next_r.pin_oe_n[g][y] = 1'b1;
            end
          endcase
        end
      end
      next_r.periph_in[g] = r.filt[g];
    end
    // Register writes
    if (wr_now) begin
      for (int g = 0; g < PGM_GROUPS; g++) begin
        if (addr_group == g[0]) begin
          case (local_ofs)
            ADDR_W'(PGM_OFS_DATA): next_r.out_value[g] = wdata16[15:8];
            ADDR_W'(PGM_OFS_IOEN): begin
              next_r.input_enable[g] = wdata16[15:8];
              next_r.output_enable[g] = wdata16[7:0];
            end
            ADDR_W'(PGM_OFS_RCTL): begin
              next_r.pull_direction[g] = wdata16[15:8];
              next_r.pull_enable[g] = wdata16[7:0];
            end
            ADDR_W'(PGM_OFS_INTF): flag_clr[g] = wdata16[7:0]; // [R03]
            ADDR_W'(PGM_OFS_INTCTL): begin
              next_r.edge_select[g] = wdata16[15:8];
              next_r.irq_enable[g] = wdata16[7:0];
            end
            ADDR_W'(PGM_OFS_FILTER): begin
              if (g == 0) begin
                next_r.filter_enable = wdata16[7:0];
              end
            end
            ADDR_W'(PGM_OFS_MODE): next_r.role_select[g] = wdata16[7:0];
            ADDR_W'(PGM_OFS_FUNC): next_r.func_field[g] = wdata16; // [R05]
            default: next_r.pslverr = r.pslverr;
          endcase
        end
      end
    end
    // New edges win over a clear in the same cycle
    for (int g = 0; g < PGM_GROUPS; g++) begin
      next_r.irq_flag[g] = (r.irq_flag[g] & ~flag_clr[g]) | edge_hit[g]; // [R03] [R13]
    end
    next_r.irq = |({next_r.irq_flag[1], next_r.irq_flag[0]} &
                   {next_r.irq_enable[1], next_r.irq_enable[0]}); // [R13]
    // APB: answer is prepared in the setup cycle, so every access has no wait state
    next_r.pready = psel && !penable;
    if (psel && !penable) begin
      next_r.pslverr = !addr_ok;
      next_r.prdata = addr_ok ? {16'h0000, read_reg(r, addr_group ? 1 : 0, local_ofs)}
                              : 32'h0000_0000; // [R12]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0; // [R12]
      r.pin_oe_n <= '1;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign grp1_pin_out = r.pin_out[0];
  assign grp1_pin_oe_n = r.pin_oe_n[0];
  assign grp1_pull_enable = r.pull_enable[0];
  assign grp1_pull_direction = r.pull_direction[0];
  assign grp1_pad_input_enable = r.input_enable[0];
  assign grp1_periph_in = r.periph_in[0];
  assign grp2_pin_out = r.pin_out[1];
  assign grp2_pin_oe_n = r.pin_oe_n[1];
  assign grp2_pull_enable = r.pull_enable[1];
  assign grp2_pull_direction = r.pull_direction[1];
  assign grp2_pad_input_enable = r.input_enable[1];
  assign grp2_periph_in = r.periph_in[1];
  assign irq = r.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_apb_write(logic [ADDR_W-1:0] a);
    psel && penable && pwrite && pready && !pslverr && paddr == a;
  endsequence

  chk_flag_w1c_clear: assert property ( // [R03]
    s_apb_write(ADDR_W'(PGM_OFS_INTF)) ##0 (pwdata[0] && !edge_hit[0][0])
      |=> !r.irq_flag[0][0])
    else $error("flag not cleared by writing one");

  chk_flag_zero_keeps: assert property ( // [R03]
    s_apb_write(ADDR_W'(PGM_OFS_INTF)) ##0 (!pwdata[1] && r.irq_flag[0][1])
      |=> r.irq_flag[0][1])
    else $error("flag lost on writing zero");

  chk_gpio_mode_drive: assert property ( // [R04]
    r.role_select[0] == 8'h00 |=> grp1_pin_out == $past(r.out_value[0])
      && grp1_pin_oe_n == ~$past(r.output_enable[0]))
    else $error("GPIO mode does not drive output value");

  chk_func0_map: assert property ( // [R06]
    r.role_select[0][6] && r.func_field[0][13:12] == 2'b00
      |=> grp1_pin_out[6] == $past(grp1_func0_out[6]))
    else $error("function 0 not routed");

  chk_g1_func_none: assert property ( // [R07]
    r.role_select[0][3] && r.func_field[0][7] |=> grp1_pin_oe_n[3])
    else $error("unassigned function drives pin");

  chk_mux_hand: assert property ( // [R08]
    r.role_select[1][2] && r.func_field[1][5:4] == 2'b01
      |=> grp2_pin_oe_n[2] == !$past(grp2_mux_drive[2]))
    else $error("multiplexer function not routed");

  chk_lcd_segment: assert property ( // [R10]
    r.role_select[1][7] && r.func_field[1][15:14] == 2'b11
      |=> grp2_pin_out[7] == $past(grp2_lcd_seg_out[7]))
    else $error("LCD segment not routed");

  chk_g2_filter_zero: assert property ( // [R11]
    psel && !penable && paddr == ADDR_W'(PGM_GROUP_STRIDE + PGM_OFS_FILTER)
      |=> prdata == 32'h0000_0000 && pready)
    else $error("group two filter register not zero");

  chk_read_upper_zero: assert property ( // [R12]
    pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");

  chk_edge_sets_flag: assert property ( // [R13]
    !r.edge_select[1][0] && !r.in_value[1][0] ##1 r.in_value[1][0] |-> r.irq_flag[1][0])
    else $error("rising edge did not set flag");

  // Output and flags are registered together, so they must agree at every edge
  chk_irq_level: assert property ( // [R13]
    irq == |({r.irq_flag[1], r.irq_flag[0]} & {r.irq_enable[1], r.irq_enable[0]}))
    else $error("interrupt output wrong");

  sequence s_ok_answer;
    pready && !pslverr ##1 !pready;
  endsequence

  sequence s_err_answer;
    pready && pslverr && prdata == 32'h0000_0000 ##1 !pready;
  endsequence

  chk_ready_pulse: assert property (
    psel && !penable && paddr <= ADDR_W'(PGM_GROUP_STRIDE + PGM_OFS_FUNC)
      && paddr[1:0] == 2'b00 |=> s_ok_answer)
    else $error("access not answered in one cycle");

  chk_unmapped_err: assert property ( // [R12]
    psel && !penable
      && (paddr > ADDR_W'(PGM_GROUP_STRIDE + PGM_OFS_FUNC) || paddr[1:0] != 2'b00)
      |=> s_err_answer)
    else $error("unmapped access not refused");

  chk_buzzer_drive: assert property ( // [R06]
    r.role_select[0][4] && r.func_field[0][9:8] == 2'b00
      |=> grp1_pin_oe_n[4] == !$past(grp1_func0_drive[4]))
    else $error("function 0 drive not routed");

  chk_g2_func0_map: assert property ( // [R09]
    r.role_select[1][4] && r.func_field[1][9:8] == 2'b00
      |=> grp2_pin_out[4] == $past(grp2_func0_out[4])
      && grp2_pin_oe_n[4] == !$past(grp2_func0_drive[4]))
    else $error("group two function 0 not routed");

  chk_g2_func2_none: assert property ( // [R10]
    r.role_select[1][0] && r.func_field[1][1:0] == 2'b10 |=> grp2_pin_oe_n[0] && !grp2_pin_out[0])
    else $error("group two function 2 drives pin");

  chk_g2_gpio_drive: assert property ( // [R04]
    !r.role_select[1][5] |=> grp2_pin_out[5] == $past(r.out_value[1][5])
      && grp2_pin_oe_n[5] == !$past(r.output_enable[1][5]))
    else $error("group two GPIO mode does not drive output value");

endmodule

/* core/pgm_pkg.sv */
// Package of constants for the two-group GPIO port and pin mux
// Operation
// R01 - Group one: eight GPIO pins with interrupts
// R02 - Group two: eight GPIO pins with interrupts
// R03 - Writing one clears interrupt flag bit
// R04 - Mode bit zero GPIO, one peripheral
// R05 - Two-bit function field per pin
// R06 - Group one function 0 peripheral map
// R07 - Group one functions 2, 3 unassigned
// R08 - Function 1 hands pin to multiplexer
// R09 - Group two function 0 converter map
// R10 - Group two function 3 LCD segments
// R11 - Group two filter register reads zero
// R12 - Reset clears fields; upper bits zero
// R13 - Edge sets flag; enabled flags raise interrupt
package pgm_pkg;
  localparam int PGM_PINS = 8;
  localparam int PGM_GROUPS = 2;
  // Byte offsets inside one group; group two sits one stride above
  localparam logic [7:0] PGM_OFS_DATA = 8'h00;
  localparam logic [7:0] PGM_OFS_IOEN = 8'h04;
  localparam logic [7:0] PGM_OFS_RCTL = 8'h08;
  localparam logic [7:0] PGM_OFS_INTF = 8'h0C;
  localparam logic [7:0] PGM_OFS_INTCTL = 8'h10;
  localparam logic [7:0] PGM_OFS_FILTER = 8'h14;
  localparam logic [7:0] PGM_OFS_MODE = 8'h18;
  localparam logic [7:0] PGM_OFS_FUNC = 8'h1C;
  localparam logic [7:0] PGM_GROUP_STRIDE = 8'h20;
  localparam logic [7:0] PGM_RESET_BYTE = 8'h00;
  localparam logic [15:0] PGM_RESET_HALF = 16'h0000;
  localparam logic [15:0] PGM_FILTER_G2_VALUE = 16'h0000;
  localparam int PGM_FIELD_W = 2;
  typedef enum logic [1:0] {
    PGM_FUNC_0 = 2'b00,
    PGM_FUNC_MUX = 2'b01,
    PGM_FUNC_2 = 2'b10,
    PGM_FUNC_3 = 2'b11
  } pgm_func_type;
endpackage

/* verification/pgm_pad_model.sv */
// Pad wires of one group: design drive, external drive, pull or float
`timescale 1ns/1ps
module pgm_pad_model (
  input wire logic pclk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] oe_n,
  input wire logic [7:0] pull_en,
  input wire logic [7:0] pull_dir,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin_in
);
  logic [7:0] wobble = 8'h00;
  // A floating wire toggles so a stale level never passes for data
  always @(posedge pclk) wobble <= ~wobble;
  always_comb begin
    for (int y = 0; y < 8; y++) begin
      if (!oe_n[y]) pin_in[y] = pin_out[y];
      else if (ext_en[y]) pin_in[y] = ext_val[y];
      else if (pull_en[y]) pin_in[y] = pull_dir[y];
      else pin_in[y] = wobble[y];
    end
  end
endmodule

/* verification/test_port_group_one_two_gpio_mux.sv */
// Self-checking bench for the two-group GPIO port and pin mux
`timescale 1ns/1ps
module test_port_group_one_two_gpio_mux import pgm_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rv;
  logic pready, pslverr, irq, re;
  logic [7:0] pin[2], po[2], oe[2], pe[2], pd[2];
  logic [7:0] f0o[2], f0d[2], mxo[2], mxd[2], xv[2], xe[2];
  logic [7:0] ien[2], pfi[2];
  logic [7:0] lcdo = 8'h00;
  logic [7:0] lcdd = 8'h00;
  int bad_count = 0;
  int checked = 0;
  always #5 pclk = ~pclk;
  pgm_port u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .grp1_pin_in(pin[0]), .grp1_pin_out(po[0]),
    .grp1_pin_oe_n(oe[0]), .grp1_pull_enable(pe[0]), .grp1_pull_direction(pd[0]),
    .grp1_pad_input_enable(ien[0]), .grp1_periph_in(pfi[0]), .grp1_func0_out(f0o[0]),
    .grp1_func0_drive(f0d[0]), .grp1_mux_out(mxo[0]), .grp1_mux_drive(mxd[0]),
    .grp2_pin_in(pin[1]), .grp2_pin_out(po[1]), .grp2_pin_oe_n(oe[1]),
    .grp2_pull_enable(pe[1]), .grp2_pull_direction(pd[1]),
    .grp2_pad_input_enable(ien[1]), .grp2_periph_in(pfi[1]), .grp2_func0_out(f0o[1]),
    .grp2_func0_drive(f0d[1]), .grp2_mux_out(mxo[1]), .grp2_mux_drive(mxd[1]),
    .grp2_lcd_seg_out(lcdo), .grp2_lcd_seg_drive(lcdd), .irq(irq));
  for (genvar g = 0; g < 2; g++) begin : g_pad
    pgm_pad_model u_pad (.pclk(pclk), .pin_out(po[g]), .oe_n(oe[g]), .pull_en(pe[g]),
      .pull_dir(pd[g]), .ext_val(xv[g]), .ext_en(xe[g]), .pin_in(pin[g]));
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    checked++;
    if (got !== ex) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Setup, access, then hold until pready is seen at a rising edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      bad_count++;
      wrap_up();
    end
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic t_reset();
    for (int a = 0; a < 64; a += 4) begin
      apb(8'(a), 1'b0, 32'h0);
      chk("reset reg", 16'h0000, rv[15:0]);
      chk("upper half", 16'h0000, rv[31:16]);
    end
    chk("oe_n reset", 16'h00FF, {8'h00, oe[0]});
    apb(8'h40, 1'b0, 32'h0);
    chk("unmapped err", 16'h0001, {15'h0, re});
    $display("reset test done");
  endtask
  task automatic t_regs();
    logic [7:0] ad[5] = '{8'h18, 8'h34, 8'h14, 8'h3C, 8'h0C};
    logic [15:0] ex[5] = '{16'h00FF, 16'h0000, 16'h00FF, 16'hFFFF, 16'h0000};
    for (int i = 0; i < 5; i++) begin
      wr(ad[i], 32'hFFFF_FFFF);
      apb(ad[i], 1'b0, 32'h0);
      chk("reg access", ex[i], rv[15:0]);
      wr(ad[i], 32'h0);
    end
    $display("register test done");
  endtask
  task automatic t_gpio(input int g);
    logic [7:0] b;
    int n;
    b = g[0] ? PGM_GROUP_STRIDE : 8'h00;
    wr(b + PGM_OFS_RCTL, 32'h0000_0F33);
    cyc(1);
    chk("pull", 16'h0F33, {pd[g], pe[g]});
    wr(b + PGM_OFS_IOEN, 32'h0000_00FF);
    wr(b + PGM_OFS_DATA, 32'h0000_A500);
    cyc(3);
    chk("pin_out", 16'h00A5, {8'h00, po[g]});
    chk("oe_n", 16'h0000, {8'h00, oe[g]});
    wr(b + PGM_OFS_IOEN, 32'h0000_FF00);
    xe[g] <= 8'hFF;
    xv[g] <= 8'h3C;
    wr(b + PGM_OFS_INTCTL, 32'h0000_0201);
    cyc(6);
    apb(b + PGM_OFS_DATA, 1'b0, 32'h0);
    chk("data read", 16'hA53C, rv[15:0]);
    chk("periph in", 16'h003C, {8'h00, pfi[g]});
    chk("input enable", 16'h00FF, {8'h00, ien[g]});
    // The hand-over from own drive to external drive leaves edges behind
    wr(b + PGM_OFS_INTF, 32'h0000_00FF);
    cyc(1);
    chk("stale clear", 16'h0000, {15'h0, irq});
    xv[g] <= 8'h3D;
    for (n = 0; n < 10 && irq !== 1'b1; n++) @(posedge pclk);
    chk("irq raise", 16'h0001, {15'h0, irq});
    if (irq !== 1'b1) wrap_up();
    wr(b + PGM_OFS_INTF, 32'h0);
    apb(b + PGM_OFS_INTF, 1'b0, 32'h0);
    chk("flag kept", 16'h0001, rv[15:0]);
    wr(b + PGM_OFS_INTF, 32'h1);
    cyc(2);
    chk("irq clear", 16'h0000, {15'h0, irq});
    xv[g] <= 8'h3F;
    cyc(6);
    xv[g] <= 8'h3C;
    cyc(6);
    apb(b + PGM_OFS_INTF, 1'b0, 32'h0);
    // Pin 1 rose then fell under falling select; pin 0 fall is ignored
    chk("edge select", 16'h0002, rv[15:0]);
    chk("irq masked", 16'h0000, {15'h0, irq});
    wr(b + PGM_OFS_INTF, 32'h1);
    apb(b + PGM_OFS_INTF, 1'b0, 32'h0);
    chk("flag 1 kept", 16'h0002, rv[15:0]);
    wr(b + PGM_OFS_INTF, 32'h2);
    apb(b + PGM_OFS_INTF, 1'b0, 32'h0);
    chk("flag 1 clear", 16'h0000, rv[15:0]);
    wr(b + PGM_OFS_INTCTL, 32'h0);
    wr(b + PGM_OFS_IOEN, 32'h0);
    wr(b + PGM_OFS_RCTL, 32'h0);
    xe[g] <= 8'h00;
    $display("gpio test done");
  endtask
  task automatic t_mux(input int g);
    logic [7:0] b, ed, eo;
    logic [15:0] w;
    logic [1:0] fn;
    logic [31:0] sd, so;
    b = g[0] ? PGM_GROUP_STRIDE : 8'h00;
    f0o[g] <= 8'h5A;
    f0d[g] <= 8'hF0;
    mxo[g] <= 8'hC3;
    mxd[g] <= 8'h0F;
    lcdo <= 8'h99;
    lcdd <= 8'h3C;
    wr(b + PGM_OFS_MODE, 32'h0000_00FF);
    sd = {g[0] ? lcdd : 8'h00, 8'h00, mxd[g], f0d[g]};
    so = {g[0] ? lcdo : 8'h00, 8'h00, mxo[g], f0o[g]};
    // Rotate fields so every pin meets every function code
    for (int f = 0; f < 4; f++) begin
      for (int y = 0; y < 8; y++) begin
        fn = 2'(y + f);
        w[2*y +: 2] = fn;
        ed[y] = sd[8*fn + y];
        eo[y] = so[8*fn + y];
      end
      wr(b + PGM_OFS_FUNC, {16'h0000, w});
      cyc(3);
      chk("mux oe_n", {8'h00, ~ed}, {8'h00, oe[g]});
      chk("mux out", {8'h00, eo & ed}, {8'h00, po[g] & ed});
    end
    wr(b + PGM_OFS_MODE, 32'h0);
    cyc(3);
    chk("gpio back", 16'h00FF, {8'h00, oe[g]});
    $display("mux test done");
  endtask
  initial begin
    for (int g = 0; g < 2; g++) begin
      f0o[g] = 8'h00;
      f0d[g] = 8'h00;
      mxo[g] = 8'h00;
      mxd[g] = 8'h00;
      xv[g] = 8'h00;
      xe[g] = 8'h00;
    end
    cyc(20);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    for (int g = 0; g < 2; g++) begin
      t_gpio(g);
      t_mux(g);
    end
    wrap_up();
  end
endmodule
